//--- hdl/vip_top.sv
// Vectored interrupt priority and vector fetch address logic
`timescale 1ns/1ps
module vip_top (
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  // Interrupt sources, one per vector, from same-clock logic
  input  wire logic [vip_pkg::NUM_VEC-1:0] irq_pend,
  // Programmed levels, two bits per vector, used where programmable
  input  wire logic [2*vip_pkg::NUM_VEC-1:0] irq_lvl,
  // Reset causes
  input  wire logic                        chip_rst_req,
  input  wire logic                        wdog_rst_req,
  // Core side
  input  wire logic [23:0]                 vector_base_pointer,
  input  wire logic [1:0]                  core_mask_lvl,
  input  wire logic                        core_ack,
  output vip_pkg::vip_req_s                req_out,
  // Jump target truncation and memory decode
  input  wire logic [23:0]                 jump_target,
  output logic [18:0]                      jump_target_lim,
  input  wire logic [23:0]                 prog_addr,
  output vip_pkg::vip_map_s                map_out
);
  import vip_pkg::*;

  // Effective level of one vector; used in the generate loop
  function automatic logic [2:0] eff_level(input logic [5:0] v, input logic [1:0] lvl);
    logic [2:0] r;
    r = ELVL_NONE;
    if (RESERVED_MASK[v])
      r = ELVL_NONE;
    else if (v >= VEC_CORE_LO && v <= VEC_CORE_HI)
      r = ELVL_L3;
    else if (v >= VEC_DBG_LO && v <= VEC_DBG_HI)
      r = ELVL_OFS + ((lvl == 2'h0) ? 3'h1 : 3'(lvl));
    else if (v == VEC_SW2)
      r = ELVL_OFS + 3'h2;
    else if (v == VEC_SW1)
      r = ELVL_OFS + 3'h1;
    else if (v == VEC_SW0)
      r = ELVL_OFS;
    else if (v == VEC_SW_LP)
      r = ELVL_LP;
    else if (v >= VEC_PERIPH_LO)
      r = ELVL_OFS + ((lvl == 2'h3) ? 3'h2 : 3'(lvl));
    return r;
  endfunction

  // Flattened effective levels; vectors 0 and 1 are resets, not interrupts
  logic [3*NUM_VEC-1:0] elvl_flat;   // Per-vector effective level
  logic [NUM_VEC-1:0]   pend_ok;     // Pending and at or above the core mask, or level -1 under mask 0
  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_lvl
      logic [2:0] el;
      // Source n sits at bit n: flash, SPI and converter keep their numbers
      assign el = (g <= VEC_WDOG) ? ELVL_NONE : eff_level(6'(g), irq_lvl[2*g +: 2]);
      assign elvl_flat[3*g +: 3] = el;
      // Level -1 passes only when the core mask is 0; any higher mask holds it off
      assign pend_ok[g] = irq_pend[g] && (el != ELVL_NONE) &&
                          ((el >= ELVL_OFS + 3'(core_mask_lvl)) || el == ELVL_LP && core_mask_lvl == 2'h0);
    end
  endgenerate

  // Arbitration
  logic       win_valid;  // A request survived
  logic [5:0] win_vec;    // Winning vector
  logic [2:0] win_elvl;   // Its level
  vip_arbiter #(.N(NUM_VEC)) u_arb (
    .pend      (pend_ok),
    .elvl_flat (elvl_flat),
    .win_valid (win_valid),
    .win_vec   (win_vec),
    .win_elvl  (win_elvl)
  );

  // Fetch address: base plus two words per entry
  function automatic logic [23:0] fetch_of(input logic [23:0] base, input logic [5:0] v);
    return base + {17'h0, v, 1'b0};
  endfunction

  // Presentation state: the winner is held stable until the core takes it
  vip_state_e state_r;
  vip_req_s   req_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= VIP_IDLE;
      req_r   <= '0;
    end else if (clk_en) begin
      case (state_r)
        VIP_IDLE: begin
          // Resets take precedence over any interrupt
          if (chip_rst_req) begin
            req_r   <= '{1'b1, VEC_RESET, ELVL_L3, fetch_of(vector_base_pointer, VEC_RESET)};
            state_r <= VIP_PRESENT;
          end else if (wdog_rst_req) begin
            req_r   <= '{1'b1, VEC_WDOG, ELVL_L3, fetch_of(vector_base_pointer, VEC_WDOG)};
            state_r <= VIP_PRESENT;
          end else if (win_valid) begin
            req_r   <= '{1'b1, win_vec, win_elvl, fetch_of(vector_base_pointer, win_vec)};
            state_r <= VIP_PRESENT;
          end
        end
        VIP_PRESENT: begin
          // Drop once the core acknowledges; rearbitrate next cycle
          if (core_ack) begin
            req_r.valid <= 1'b0;
            state_r     <= VIP_IDLE;
          end
        end
        default: begin
          state_r <= VIP_IDLE;
          req_r   <= '0;
        end
      endcase
    end
  end
  assign req_out = req_r;

  // Jump target cut to its low 19 bits, registered; upper bits unreachable from the table
  always_ff @(posedge clk) begin
    if (!rst_b)
      jump_target_lim <= '0;
    else if (clk_en)
      jump_target_lim <= jump_target[TGT_W-1:0];
  end

  // Program address falls in the RAM overlay window
  function automatic logic in_pram(input logic [23:0] a);
    return (a >= PRAM_BASE) && (a <= PRAM_END);
  endfunction

  // Program space decode: flash low, RAM overlay mapped to data word 0
  always_ff @(posedge clk) begin
    if (!rst_b)
      map_out <= '0;
    else if (clk_en) begin
      map_out.in_flash  <= (prog_addr <= PROG_FLASH_END);
      map_out.in_ram    <= in_pram(prog_addr);
      map_out.data_addr <= in_pram(prog_addr) ?
                           (prog_addr - PRAM_BASE + DRAM_BASE) : '0;
    end
  end

  // Checks
  reserved_never_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_out.valid |-> !RESERVED_MASK[req_out.vec]) else $error("reserved vector presented");
  fetch_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(req_out.valid) |-> req_out.fetch_addr == $past(vector_base_pointer) + {17'h0, req_out.vec, 1'b0})
    else $error("fetch address wrong");
  core_fixed_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_out.valid && req_out.vec >= VEC_CORE_LO && req_out.vec <= VEC_CORE_HI |-> req_out.elvl == ELVL_L3)
    else $error("core exception level wrong");
  reset_vec_a: assert property (@(posedge clk) disable iff (!rst_b)
    $past(clk_en) && $past(state_r) == VIP_IDLE && $past(chip_rst_req) |-> req_out.vec == VEC_RESET)
    else $error("reset vector wrong");
  boot_align_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(req_out.valid) && req_out.vec == VEC_WDOG && $past(vector_base_pointer) == VBP_RESET |->
    req_out.fetch_addr == WDOG_ADDR) else $error("watchdog entry misplaced");
  mask_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(req_out.valid) && req_out.vec > VEC_WDOG && req_out.elvl != ELVL_LP |->
    req_out.elvl >= ELVL_OFS + 3'($past(core_mask_lvl))) else $error("masked level presented");
  periph_lvl_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_out.valid && req_out.vec >= VEC_PERIPH_LO && req_out.vec != VEC_SW_LP |->
    req_out.elvl <= ELVL_OFS + 3'h2) else $error("peripheral level above 2");
  dbg_lvl_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_out.valid && req_out.vec >= VEC_DBG_LO && req_out.vec <= VEC_DBG_HI |->
    req_out.elvl >= ELVL_OFS + 3'h1) else $error("debug level below 1");
  ram_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && $past(clk_en) && $past(prog_addr) == PRAM_BASE |-> map_out.in_ram && map_out.data_addr == DRAM_BASE)
    else $error("ram overlay wrong");
  hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    req_out.valid && !core_ack |=> req_out.valid && $stable(req_out.vec)) else $error("request dropped early");
endmodule

//--- hdl/vip_pkg.sv
// Package for the vectored interrupt priority block: vectors, levels, memory map
package vip_pkg;
  localparam int VEC_W       = 6;               // Vector number width
  localparam int NUM_VEC     = 46;              // Vectors 0..45
  localparam int LVL_W       = 2;               // Programmable level field width
  localparam int ADDR_W      = 24;              // Program word address width
  localparam int TGT_W       = 19;              // Reachable jump target width
  localparam int WORDS_PER_VEC_SH = 1;          // Two words per entry (shift)
  // Fixed vector numbers
  localparam logic [5:0] VEC_RESET      = 6'h00;
  localparam logic [5:0] VEC_WDOG       = 6'h01;
  localparam logic [5:0] VEC_CORE_LO    = 6'h02;
  localparam logic [5:0] VEC_CORE_HI    = 6'h05;
  localparam logic [5:0] VEC_DBG_LO     = 6'h06;
  localparam logic [5:0] VEC_DBG_HI     = 6'h0a;
  localparam logic [5:0] VEC_SW2        = 6'h0b;
  localparam logic [5:0] VEC_SW1        = 6'h0c;
  localparam logic [5:0] VEC_SW0        = 6'h0d;
  localparam logic [5:0] VEC_PERIPH_LO  = 6'h10;
  localparam logic [5:0] VEC_PLL        = 6'h11;
  localparam logic [5:0] VEC_FLASH_ERR  = 6'h12;
  localparam logic [5:0] VEC_FLASH_DONE = 6'h13;
  localparam logic [5:0] VEC_FLASH_EMPTY = 6'h14;
  localparam logic [5:0] VEC_SPI_RX     = 6'h1a;
  localparam logic [5:0] VEC_ADC_ZC     = 6'h2a;
  localparam logic [5:0] VEC_SW_LP      = 6'h2d;
  localparam logic [45:0] RESERVED_MASK = 46'h0006_0020_c000; // 14,15,21,33,34
  // Memory map, program word addresses
  localparam logic [23:0] VBP_RESET      = 24'h00_0000; // Entries 0, 1 land on reset fetches
  localparam logic [23:0] BOOT_ADDR      = 24'h00_0000;
  localparam logic [23:0] WDOG_ADDR      = 24'h00_0002;
  localparam logic [23:0] PROG_FLASH_END = 24'h00_1fff;
  localparam logic [23:0] PRAM_BASE      = 24'h00_8000;
  localparam logic [23:0] PRAM_END       = 24'h00_87ff;
  localparam logic [23:0] DRAM_BASE      = 24'h00_0000;
  // Effective level encoding: 0 none, 1 = level -1, 2..5 = levels 0..3
  localparam logic [2:0] ELVL_NONE = 3'h0;
  localparam logic [2:0] ELVL_LP   = 3'h1;
  localparam logic [2:0] ELVL_OFS  = 3'h2;
  localparam logic [2:0] ELVL_L3   = 3'h5;

  typedef enum logic [1:0] { VIP_IDLE, VIP_PRESENT } vip_state_e;
  // Winner toward the core
  typedef struct packed {
    logic              valid;
    logic [5:0]        vec;
    logic [2:0]        elvl;
    logic [23:0]       fetch_addr;
  } vip_req_s;
  // Memory space decode result
  typedef struct packed {
    logic        in_flash;
    logic        in_ram;
    logic [23:0] data_addr;
  } vip_map_s;
endpackage

//--- hdl/vip_arbiter.sv
// Combinational priority arbiter over pending vectors
`timescale 1ns/1ps
module vip_arbiter #(
  parameter int N = 46
) (
  // Inputs
  input  wire logic [N-1:0]   pend,
  input  wire logic [3*N-1:0] elvl_flat,
  // Result
  output logic                win_valid,
  output logic [5:0]          win_vec,
  output logic [2:0]          win_elvl
);
  import vip_pkg::*;
  // Vector numbers are six bits wide, so more than 64 sources cannot be named
  if (N < 1 || N > 64) begin : g_bad_n
    $error("vip_arbiter: N out of range");
  end
  // Scan from high vector down so the lowest number among equals wins
  always_comb begin
    win_valid = 1'b0;
    win_vec   = 6'h00;
    win_elvl  = ELVL_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      // Strictly higher level wins; equal level goes to lower index
      if (pend[i] && (elvl_flat[3*i +: 3] >= win_elvl) && (elvl_flat[3*i +: 3] != ELVL_NONE)) begin
        win_valid = 1'b1;
        win_vec   = 6'(i);
        win_elvl  = elvl_flat[3*i +: 3];
      end
    end
  end
endmodule

//--- test/vip_core_model.sv
// Processor core model: takes each presented vector after a short or long delay
`timescale 1ns/1ps
module vip_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Presented request and pacing
  input  wire logic req_valid,
  input  wire logic slow,
  // Acknowledge toward the block
  output logic      core_ack
);
  logic [2:0] wait_r;  // Cycles spent looking at the vector

  // One-cycle ack pulse; cleared at once so a held valid is never acked twice
  always_ff @(posedge clk) begin
    if (!rst_b || !req_valid || core_ack) begin
      wait_r   <= 3'h0;
      core_ack <= 1'b0;
    end else if (wait_r >= (slow ? 3'h5 : 3'h1)) begin
      core_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 3'h1;
    end
  end
endmodule

//--- test/tb_top.sv
// Self-checking testbench for the vectored interrupt priority block
`timescale 1ns/1ps
module tb_top;
  import vip_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic [45:0] irq_pend = '0;
  logic [91:0] irq_lvl = '0;
  logic        chip_rst_req = 1'b0;
  logic        wdog_rst_req = 1'b0;
  logic [23:0] base_r = '0;
  logic [1:0]  mask_r = '0;
  logic        slow = 1'b0;
  logic        core_ack;
  logic [23:0] jump_target = '0;
  logic [23:0] prog_addr = '0;
  logic [18:0] lim;
  vip_req_s    req_out;
  vip_map_s    map_out;
  logic [5:0]  exp_v[$];         // Awaited vectors, oldest first
  logic [2:0]  exp_l[$];         // Awaited levels, 7 means not checked
  logic [23:0] exp_a[$];         // Awaited fetch addresses
  int          n_errors = 0;
  int          num_checks = 0;
  int          lone_v[16] = '{2, 3, 4, 5, 7, 11, 12, 13, 16, 17, 18, 19, 20, 26, 42, 45};
  logic [23:0] maps[10] = '{24'h0, WDOG_ADDR, PROG_FLASH_END, 24'h2000, PRAM_BASE, PRAM_END, 24'h8800,
                            24'h8123, 24'h0abc, 24'hfff000};

  always #2 clk = ~clk;

  vip_top u_vip_top (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .irq_pend(irq_pend), .irq_lvl(irq_lvl),
    .chip_rst_req(chip_rst_req), .wdog_rst_req(wdog_rst_req), .vector_base_pointer(base_r),
    .core_mask_lvl(mask_r), .core_ack(core_ack), .req_out(req_out), .jump_target(jump_target),
    .jump_target_lim(lim), .prog_addr(prog_addr), .map_out(map_out));
  vip_core_model u_vip_core_model (.clk(clk), .rst_b(rst_b), .req_valid(req_out.valid), .slow(slow),
    .core_ack(core_ack));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Level the block should report for a source
  function automatic logic [2:0] lvl_of(input int v, input logic [1:0] l);
    if (v <= 5) return ELVL_L3;
    if (v <= 10) return ELVL_OFS + ((l == 2'h0) ? 3'h1 : {1'b0, l});
    if (v <= 13) return ELVL_OFS + 3'(13 - v);
    if (v == 45) return ELVL_LP;
    return ELVL_OFS + ((l == 2'h3) ? 3'h2 : {1'b0, l});
  endfunction

  task automatic note(input logic [5:0] v, input logic [2:0] l, input logic [23:0] a);
    exp_v.push_back(v);
    exp_l.push_back(l);
    exp_a.push_back(a);
  endtask

  task automatic raise(input int v, input logic [1:0] l);
    irq_pend[v] <= 1'b1;
    irq_lvl[2*v +: 2] <= l;
  endtask

  // Raise a source and await it at base plus two words per entry
  task automatic post(input int v, input logic [1:0] l);
    raise(v, l);
    note(6'(v), lvl_of(v, l), base_r + 24'(2 * v));
  endtask

  // New scenario: sources cleared, base and mask set
  task automatic fresh(input logic [23:0] b, input logic [1:0] m);
    irq_pend <= '0;
    base_r <= b;
    mask_r <= m;
    slow <= 1'($urandom);
    @(posedge clk);
  endtask

  // Play the source side until all notes are taken, then watch a quiet spell
  task automatic drain(input string name);
    for (int k = 0; k < 400 && exp_v.size() > 0; k++) begin
      @(posedge clk);
      if (req_out.valid === 1'b1) begin
        irq_pend[req_out.vec] <= 1'b0;
        if (req_out.vec == VEC_RESET) chip_rst_req <= 1'b0;
        if (req_out.vec == VEC_WDOG) wdog_rst_req <= 1'b0;
      end
    end
    chk(32'(exp_v.size()), 32'h0, "vectors never presented");
    repeat (24) @(posedge clk);
    $display("test %s done", name);
  endtask

  // Compare each taken vector against the oldest note
  always @(posedge clk) begin
    if (rst_b && req_out.valid === 1'b1 && core_ack === 1'b1) begin
      if (exp_v.size() == 0) chk(32'h1, 32'h0, "unexpected vector");
      else begin
        chk(32'(req_out.vec), 32'(exp_v.pop_front()), "vector");
        if (exp_l[0] != 3'h7) chk(32'(req_out.elvl), 32'(exp_l[0]), "level");
        void'(exp_l.pop_front());
        chk(32'(req_out.fetch_addr), 32'(exp_a.pop_front()), "fetch address");
      end
    end
  end

  initial begin
    #(4 * 20000);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(51));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (lone_v[i]) begin
      fresh(24'($urandom), 2'h0);
      post(lone_v[i], 2'($urandom));
      drain("lone source");
    end
    fresh(24'($urandom), 2'h0);
    post(3, 2'h0); post(16, 2'h2); post(17, 2'h2); post(6, 2'h1);
    post(13, 2'h0); post(20, 2'h0); post(45, 2'h0);
    drain("priority order");
    fresh(24'($urandom), 2'h2);
    post(7, 2'h3); post(11, 2'h0);
    raise(12, 2'h0); raise(16, 2'h1); raise(45, 2'h0);
    drain("mask above");
    mask_r <= 2'h0;
    note(6'd12, lvl_of(12, 2'h0), base_r + 24'd24);
    note(6'd16, lvl_of(16, 2'h1), base_r + 24'd32);
    note(6'd45, ELVL_LP, base_r + 24'd90);
    drain("mask lowered");
    fresh(24'($urandom), 2'h0);
    raise(0, 2'h2);
    raise(1, 2'h2);
    raise(14, 2'h2);
    raise(15, 2'h2);
    raise(21, 2'h2);
    raise(33, 2'h2);
    raise(34, 2'h2);
    post(22, 2'h1);
    drain("reserved skipped");
    fresh(VBP_RESET, 2'h0);
    chip_rst_req <= 1'b1;
    wdog_rst_req <= 1'b1;
    note(VEC_RESET, 3'h7, BOOT_ADDR);
    note(VEC_WDOG, 3'h7, WDOG_ADDR);
    post(2, 2'h0);
    drain("reset causes");
    // Mid-run reset while a vector is up: outputs clear, then it comes back
    fresh(24'($urandom), 2'h0);
    jump_target <= 24'($urandom) | 24'h1;
    post(5, 2'h0);
    repeat (2) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(req_out.valid), 32'h0, "valid in reset");
    chk(32'(lim), 32'h0, "target in reset");
    chk(32'(map_out), 32'h0, "map in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    drain("mid-run reset");
    foreach (maps[i]) begin
      prog_addr <= maps[i];
      jump_target <= 24'($urandom);
      @(posedge clk);
      #1;
      chk(32'(lim), 32'(jump_target[18:0]), "jump target");
      chk(32'(map_out.in_flash), 32'(maps[i] <= PROG_FLASH_END), "flash");
      chk(32'(map_out.in_ram), 32'(maps[i] >= PRAM_BASE && maps[i] <= PRAM_END), "ram");
      if (maps[i] >= PRAM_BASE && maps[i] <= PRAM_END)
        chk(32'(map_out.data_addr), 32'(DRAM_BASE + maps[i] - PRAM_BASE), "data alias");
      @(posedge clk);
    end
    $display("test memory map done");
    // Clock enable low: decode must hold its last value, then resume
    clk_en <= 1'b0;
    prog_addr <= PRAM_BASE;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(map_out.in_ram), 32'h0, "frozen map");
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(map_out.in_ram), 32'h1, "map after freeze");
    $display("test clock enable done");
    wrap_up();
  end
endmodule
